// File: core/tcif_ctrl.sv
// design: init gating and timing refinements of the token controller
// Notes on behaviour
// - idle wait on: init writes wait idle line
// - idle wait off: init writes immediately
// - node write: d1 at 000, id at 001
// - init routine decode suppresses wait instruction
// - refinement bit defaults off, enables all fixes but init gating
// - clear commands or successor read drop interrupt
// - refined disable time exceeds 200 ns
// - prescaler output picked by select field
// - refined select resynchronised before use
// - legacy command spacing from oscillator clock
// - refined command spacing 100 ns crystal
// - legacy enable commands refused during prohibition
// - refined status returns high at pulse end
// - receiver inhibited return raises interrupt when mask bit ST_RI is set
// - refined probe or node write clears lingering
// - refined mask cleared by both resets
// - legacy soft reset keeps mask
// - soft reset on node zero or reset bit
// - soft reset sets both status bits
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module tcif_ctrl (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // avalon-mm slave
  input  wire logic [3:0]            address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  output logic [31:0]                readdata,
  output logic                       waitrequest,
  // network and micro-program side
  input  wire logic                  line_active,
  input  wire logic                  osc_tick,
  input  wire logic                  ucode_sync,
  input  wire logic                  ta_set_pulse,
  input  wire logic                  ri_set_pulse,
  input  wire logic                  event_irq,
  input  wire logic                  successor_own_a_rd,
  // outputs
  output tcif_pkg::tcif_ram_wr_t     ram_wr,
  output logic                       ucode_stall,
  output logic [2:0]                 rate_prescale_select,
  output logic                       interrupt_out_n,
  output logic                       probe_clear,
  output logic                       en_tx_cmd,
  output logic                       en_rx_cmd
);
  import tcif_pkg::*;

  logic             line_idle_wait_disable;
  logic             refinement_enable;
  logic             soft_reset_bit;
  logic [2:0]       presc_reg;
  logic [7:0]       mask;
  logic [7:0]       own_a;
  logic [7:0]       probe_own_a;
  logic             transmitter_available;
  logic             receiver_inhibited;
  logic             irq_pend;
  logic [7:0]       irq_off_cnt;
  logic [7:0]       cmd_gap_cnt;
  logic [3:0]       prohibit_cnt;
  logic             line_meta;
  logic             line_sync;
  logic [2:0]       presc_meta;
  logic [2:0]       presc_sync;
  logic             node_wr_seen;
  logic [13:0]      init_cnt;
  logic             ri_pulse_d;
  logic             ta_pulse_d;
  tcif_init_t       init_state;
  logic             wr_ctrl;
  logic             wr_node;
  logic             wr_probe;
  logic             wr_cmd;
  logic             cmd_ok;
  logic             soft_reset;
  logic             in_init;
  logic [7:0]       cmd;
  logic             ri_rise;
  logic             rd_done;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: writes answer at once, reads one cycle later
  assign waitrequest = read && !rd_done;
  assign wr_ctrl     = write && address == REG_CTRL;
  assign wr_node     = write && address == REG_NODE;
  assign wr_probe    = write && address == REG_PROBE;
  assign wr_cmd      = write && address == REG_CMD;
  assign cmd         = writedata[7:0];
  // reset bit acts on its rising write only
  assign soft_reset  = (wr_node && cmd == NODE_ZERO)
                    || (wr_ctrl && writedata[CTRL_SRESET]
                        && !soft_reset_bit);

  // read data loaded in the first cycle, handed over in the second
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_done <= 1'b0;
    end else begin
      rd_done <= read && !rd_done;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      readdata <= 32'h0;
    end else if (read && !rd_done) begin
      case (address)
        REG_STAT: readdata <= {27'h0, ~interrupt_out_n, cmd_gap_cnt != 8'h0,
                               init_state == TCIF_IDLE && node_wr_seen,
                               receiver_inhibited, transmitter_available};
        REG_NODE:  readdata <= {24'h0, own_a};
        REG_PROBE: readdata <= {24'h0, probe_own_a};
        default:   readdata <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      line_idle_wait_disable <= 1'b0;
      refinement_enable      <= 1'b0;
      soft_reset_bit         <= 1'b0;
      presc_reg              <= PRESC_RST;
    end else if (wr_ctrl) begin
      line_idle_wait_disable <= writedata[CTRL_IDLE_DIS];
      refinement_enable      <= writedata[CTRL_REFINE];
      soft_reset_bit         <= writedata[CTRL_SRESET];
      presc_reg              <= writedata[CTRL_PRESC_LO +: 3];
    end
  end

  // mask: hard reset always, soft reset only when refined
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mask <= MASK_RST;
    end else if (soft_reset && refinement_enable) begin
      mask <= MASK_RST;
    end else if (wr_ctrl) begin
      mask <= writedata[CTRL_MASK_LO +: 8];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      own_a         <= 8'h0;
      probe_own_a <= 8'h0;
    end else begin
      if (wr_node) own_a <= cmd;
      if (wr_probe) probe_own_a <= cmd;
    end
  end

  // refined: node or probe write wipes old probe and duplicate state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      probe_clear <= 1'b0;
    end else begin
      probe_clear <= refinement_enable && (wr_node || wr_probe);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line and prescale synchronisers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      line_meta <= 1'b0;
      line_sync <= 1'b0;
    end else begin
      line_meta <= line_active;
      line_sync <= line_meta;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      presc_meta           <= PRESC_RST;
      presc_sync           <= PRESC_RST;
      rate_prescale_select <= PRESC_RST;
    end else begin
      presc_meta <= presc_reg;
      presc_sync <= presc_meta;
      rate_prescale_select <= refinement_enable ? presc_sync
                                                : presc_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // init micro-program
  assign in_init     = init_state != TCIF_IDLE;
  // wait held only outside init or when idle waiting is enabled
  assign ucode_stall = line_sync && ((ucode_sync && !in_init)
                    || (init_state == TCIF_SYNC
                        && !line_idle_wait_disable));

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      init_state   <= TCIF_IDLE;
      ram_wr       <= '0;
      node_wr_seen <= 1'b0;
      init_cnt     <= 14'h0;
    end else begin
      ram_wr.we <= 1'b0;
      if (in_init) init_cnt <= init_cnt + 14'h1;
      case (init_state)
        TCIF_IDLE: if (wr_node && cmd != NODE_ZERO) begin
          init_state   <= TCIF_SYNC;
          node_wr_seen <= 1'b1;
          init_cnt     <= 14'h0;
        end
        TCIF_SYNC: if (line_idle_wait_disable) begin
          init_state <= TCIF_W0;
        end else if (!line_sync) begin
          init_state <= TCIF_W0;
        end
        TCIF_W0: begin
          ram_wr     <= '{we: 1'b1, addr: INIT_ADDR0, data: INIT_SIG};
          init_state <= TCIF_W1;
        end
        TCIF_W1: begin
          ram_wr     <= '{we: 1'b1, addr: INIT_ADDR1, data: own_a};
          init_state <= TCIF_IDLE;
        end
        default: init_state <= TCIF_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status bits: legacy rises at pulse start, refined at pulse end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ta_pulse_d <= 1'b0;
      ri_pulse_d <= 1'b0;
    end else begin
      ta_pulse_d <= ta_set_pulse;
      ri_pulse_d <= ri_set_pulse;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      transmitter_available <= 1'b1;
      receiver_inhibited    <= 1'b1;
    end else if (soft_reset) begin
      transmitter_available <= 1'b1;
      receiver_inhibited    <= 1'b1;
    end else begin
      if (refinement_enable ? (ta_pulse_d && !ta_set_pulse)
                            : ta_set_pulse)
        transmitter_available <= 1'b1;
      else if (en_tx_cmd)
        transmitter_available <= 1'b0;
      if (refinement_enable ? (ri_pulse_d && !ri_set_pulse)
                            : ri_set_pulse)
        receiver_inhibited <= 1'b1;
      else if (en_rx_cmd)
        receiver_inhibited <= 1'b0;
    end
  end

  assign ri_rise = (refinement_enable ? (ri_pulse_d && !ri_set_pulse)
                                      : ri_set_pulse) && !receiver_inhibited;

  ////////////////////////////////////////////////////////////////////////////
  // command spacing and prohibition window
  assign cmd_ok = cmd_gap_cnt == 8'h0;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_gap_cnt <= 8'h0;
    end else if (wr_cmd && cmd_ok) begin
      cmd_gap_cnt <= refinement_enable ? 8'(CMD_GAP_CRYSTAL_CLOCK_CYC)
                                       : 8'(OSC_PER_BIT / 8 + 1);
    end else if (cmd_gap_cnt != 8'h0 && (refinement_enable || osc_tick)) begin
      cmd_gap_cnt <= cmd_gap_cnt - 8'h1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prohibit_cnt <= 4'h0;
    end else if (!refinement_enable && (ta_set_pulse || ri_set_pulse)) begin
      prohibit_cnt <= 4'(PROHIBIT_OSC_TICKS);
    end else if (prohibit_cnt != 4'h0 && osc_tick) begin
      prohibit_cnt <= prohibit_cnt - 4'h1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      en_tx_cmd <= 1'b0;
      en_rx_cmd <= 1'b0;
    end else begin
      en_tx_cmd <= wr_cmd && cmd_ok && cmd == CMD_EN_TX
                && prohibit_cnt == 4'h0;
      en_rx_cmd <= wr_cmd && cmd_ok && cmd == CMD_EN_RX
                && prohibit_cnt == 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt with minimum disable time
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_pend    <= 1'b0;
      irq_off_cnt <= 8'h0;
    end else begin
      if (!interrupt_out_n && ((wr_cmd && cmd_ok && (cmd == CMD_CLR_IRQ
          || cmd == CMD_CLR_FLAG)) || successor_own_a_rd)) begin
        irq_off_cnt <= refinement_enable ? 8'(IRQ_OFF_CYC)
                                         : 8'h1;
      end else if (irq_off_cnt != 8'h0) begin
        irq_off_cnt <= irq_off_cnt - 8'h1;
      end
      if (ri_rise && mask[ST_RI]) begin
        irq_pend <= 1'b1;
      end else if (event_irq) begin
        irq_pend <= 1'b1;
      end else if (soft_reset) begin
        irq_pend <= 1'b0;
      end
    end
  end

  assign interrupt_out_n = !(irq_pend && irq_off_cnt == 8'h0);

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_init_wr0;
    ram_wr.we && ram_wr.addr == INIT_ADDR0 && ram_wr.data == INIT_SIG;
  endsequence
  sequence s_init_wr1;
    ram_wr.we && ram_wr.addr == INIT_ADDR1 && ram_wr.data == own_a;
  endsequence
  a_init_first_wr: assert property (
    @(posedge clock) disable iff (!resetn)
    init_state == TCIF_W0 |=> s_init_wr0 ##1 s_init_wr1)
    else $error("init writes wrong");
  a_init_waits_idle: assert property (
    @(posedge clock) disable iff (!resetn)
    init_state == TCIF_SYNC && !line_idle_wait_disable && line_sync
      |=> init_state == TCIF_SYNC)
    else $error("init did not wait");
  a_init_no_wait: assert property (
    @(posedge clock) disable iff (!resetn)
    init_state == TCIF_SYNC && line_idle_wait_disable |-> !ucode_stall
      ##1 init_state == TCIF_W0)
    else $error("init stalled");
  // the time limit only binds when a busy line cannot hold init up
  a_init_limit: assert property (
    @(posedge clock) disable iff (!resetn)
    in_init && line_idle_wait_disable |-> init_cnt < 14'(INIT_LIMIT_CYC))
    else $error("init too slow");
  a_outside_wait: assert property (
    @(posedge clock) disable iff (!resetn)
    !in_init && ucode_sync && line_sync |-> ucode_stall)
    else $error("wait lost");
  // remaining high cycles must cover more than the minimum off time
  a_irq_off_time: assert property (
    @(posedge clock) disable iff (!resetn)
    $rose(interrupt_out_n) && refinement_enable && irq_pend
      |-> irq_off_cnt > 8'(IRQ_OFF_NS * CLK_MHZ / 1000))
    else $error("disable too short");
  a_mask_soft: assert property (
    @(posedge clock) disable iff (!resetn)
    soft_reset && refinement_enable |=> mask == MASK_RST)
    else $error("mask kept");
  a_mask_legacy: assert property (
    @(posedge clock) disable iff (!resetn)
    soft_reset && !refinement_enable && !wr_ctrl |=> $stable(mask))
    else $error("mask cleared");
  a_soft_status: assert property (
    @(posedge clock) disable iff (!resetn)
    soft_reset |=> transmitter_available && receiver_inhibited)
    else $error("status not set");
  a_probe_clear: assert property (
    @(posedge clock) disable iff (!resetn)
    refinement_enable && wr_probe |=> probe_clear)
    else $error("probe not cleared");
  a_prohibit: assert property (
    @(posedge clock) disable iff (!resetn)
    prohibit_cnt != 4'h0 |=> !en_rx_cmd && !en_tx_cmd)
    else $error("enable in window");
  a_cmd_gap: assert property (
    @(posedge clock) disable iff (!resetn)
    refinement_enable && wr_cmd && cmd_ok |=> !cmd_ok)
    else $error("no spacing");
endmodule : tcif_ctrl
`default_nettype wire

// File: pkg/tcif_pkg.sv
// package: constants and carriers for the token controller init and fixes
package tcif_pkg;
  // clock and timing
  localparam int CLK_MHZ              = 100;
  localparam int INIT_LIMIT_US        = 96;
  localparam int INIT_LIMIT_CYC       = INIT_LIMIT_US * CLK_MHZ;
  localparam int IRQ_OFF_NS           = 200;
  localparam int IRQ_OFF_CYC          = (IRQ_OFF_NS * CLK_MHZ + 999) / 1000 + 1;
  localparam int CMD_GAP_CRYSTAL_CLOCK_NS      = 100;
  localparam int CMD_GAP_CRYSTAL_CLOCK_CYC     = (CMD_GAP_CRYSTAL_CLOCK_NS * CLK_MHZ + 999) / 1000;
  localparam int OSC_PER_BIT          = 8;
  localparam int PROHIBIT_OSC_TICKS   = 4;
  // register offsets, byte addresses, chosen layout
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_NODE     = 4'h4;
  localparam logic [3:0] REG_PROBE    = 4'h8;
  localparam logic [3:0] REG_CMD      = 4'hc;
  localparam logic [3:0] REG_STAT     = 4'h0;
  // ctrl field positions
  localparam int CTRL_IDLE_DIS        = 0;
  localparam int CTRL_REFINE          = 1;
  localparam int CTRL_SRESET          = 2;
  localparam int CTRL_PRESC_LO        = 4;
  localparam int CTRL_MASK_LO         = 8;
  // status field positions
  localparam int ST_TA                = 0;
  localparam int ST_RI                = 1;
  localparam int ST_INIT_DONE         = 2;
  localparam int ST_CMD_BUSY          = 3;
  localparam int ST_IRQ               = 4;
  // command codes
  localparam logic [7:0] CMD_CLR_IRQ  = 8'h1e;
  localparam logic [7:0] CMD_CLR_FLAG = 8'h08;
  localparam logic [7:0] CMD_EN_TX    = 8'h03;
  localparam logic [7:0] CMD_EN_RX    = 8'h04;
  // init RAM values, soft reset node id and reset values
  localparam logic [7:0] INIT_SIG     = 8'hd1;
  localparam logic [10:0] INIT_ADDR0  = 11'h000;
  localparam logic [10:0] INIT_ADDR1  = 11'h001;
  localparam logic [7:0] NODE_ZERO    = 8'h00;
  localparam logic [2:0] PRESC_RST    = 3'h0;
  localparam logic [7:0] MASK_RST     = 8'h00;
  // ram write carrier
  typedef struct packed {
    logic        we;
    logic [10:0] addr;
    logic [7:0]  data;
  } tcif_ram_wr_t;
  // micro-program state
  typedef enum logic [1:0] {TCIF_IDLE, TCIF_SYNC, TCIF_W0, TCIF_W1} tcif_init_t;
endpackage : tcif_pkg

// File: verification/tcif_far_model.sv
// far side model: free oscillator ticks and status set pulses
`timescale 1ns/10ps
`default_nettype none
module tcif_far_model #(
  parameter int PULSE_LEN = 4
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // pulse requests from the bench
  input  wire logic ta_req,
  input  wire logic ri_req,
  // toward the block
  output logic      osc_tick,
  output logic      ta_set_pulse,
  output logic      ri_set_pulse
);
  logic [2:0] div;
  int         ta_cnt;
  int         ri_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // oscillator enable, one tick every eight clocks, never stops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div <= 3'h0;
    end else begin
      div <= div + 3'h1;
    end
  end
  assign osc_tick = (div == 3'h7);
  ////////////////////////////////////////////////////////////////////////////
  // set pulses of fixed length
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ta_cnt <= 0;
      ri_cnt <= 0;
    end else begin
      ta_cnt <= ta_req ? PULSE_LEN : ((ta_cnt > 0) ? ta_cnt - 1 : 0);
      ri_cnt <= ri_req ? PULSE_LEN : ((ri_cnt > 0) ? ri_cnt - 1 : 0);
    end
  end
  assign ta_set_pulse = (ta_cnt > 0);
  assign ri_set_pulse = (ri_cnt > 0);
endmodule : tcif_far_model
`default_nettype wire

// File: verification/token_ctrl_init_and_timing_fixes_tb_top.sv
// testbench: init gating, command spacing, interrupt and soft reset
`timescale 1ns/10ps
`default_nettype none
module token_ctrl_init_and_timing_fixes_tb_top;
  import tcif_pkg::*;
  logic         clock = 1'b0;
  logic         resetn = 1'b0;
  logic [3:0]   address = 4'h0;
  logic         read = 1'b0;
  logic         write = 1'b0;
  logic [31:0]  writedata = 32'h0;
  logic [31:0]  readdata;
  logic         waitrequest;
  logic         line_active = 1'b0;
  logic         ucode_sync = 1'b0;
  logic         ta_req = 1'b0;
  logic         ri_req = 1'b0;
  logic         event_irq = 1'b0;
  logic         successor_own_a_rd = 1'b0;
  logic         osc_tick;
  logic         ta_set_pulse;
  logic         ri_set_pulse;
  tcif_ram_wr_t ram_wr;
  logic         ucode_stall;
  logic [2:0]   rate_prescale_select;
  logic         interrupt_out_n;
  logic         probe_clear;
  logic         en_tx_cmd;
  logic         en_rx_cmd;
  int           fail_count = 0;
  int           cmp_count = 0;
  int           n_tx = 0;
  int           n_rx = 0;
  int           n_probe = 0;
  logic [18:0]  wr_log[$];
  logic [31:0]  seed = 32'h8e98116d;
  logic [31:0]  rd_last = 32'h0;
  ////////////////////////////////////////////////////////////////////////////
  tcif_ctrl DUT (.clock(clock), .resetn(resetn), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .line_active(line_active),
    .osc_tick(osc_tick), .ucode_sync(ucode_sync),
    .ta_set_pulse(ta_set_pulse), .ri_set_pulse(ri_set_pulse),
    .event_irq(event_irq), .successor_own_a_rd(successor_own_a_rd),
    .ram_wr(ram_wr), .ucode_stall(ucode_stall),
    .rate_prescale_select(rate_prescale_select),
    .interrupt_out_n(interrupt_out_n), .probe_clear(probe_clear),
    .en_tx_cmd(en_tx_cmd), .en_rx_cmd(en_rx_cmd));
  tcif_far_model FAR (.clock(clock), .resetn(resetn), .ta_req(ta_req),
    .ri_req(ri_req), .osc_tick(osc_tick), .ta_set_pulse(ta_set_pulse),
    .ri_set_pulse(ri_set_pulse));
  initial begin
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (ram_wr.we === 1'b1) wr_log.push_back({ram_wr.addr, ram_wr.data});
    if (en_tx_cmd === 1'b1) n_tx++;
    if (en_rx_cmd === 1'b1) n_rx++;
    if (probe_clear === 1'b1) n_probe++;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [31:0] ctrl_word(input logic ids,
      input logic rf, input logic [2:0] ps, input logic [7:0] mk);
    return {16'h0, mk, 1'b0, ps, 2'b00, rf, ids};
  endfunction : ctrl_word
  // high samples 10 ns apart must exceed the minimum off time
  function automatic int long_enough(input int hi);
    return int'(hi * 1000 > IRQ_OFF_NS * CLK_MHZ);
  endfunction : long_enough
  task automatic chk_word(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic chk_count(input string nm, input int e, input int g);
    cmp_count++;
    if (g != e) begin
      fail_count++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_count
  task automatic bus_req(input logic [3:0] a, input logic wr,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) fail_count++;
    rd_last = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus_req
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    bus_req(a, 1'b0, 32'h0);
    d = rd_last;
  endtask : bus_rd
  task automatic cmd_pair(input int gap, input int exp_n);
    int n0;
    do @(posedge clock); while (osc_tick !== 1'b1);
    n0 = n_tx;
    bus_req(REG_CMD, 1'b1, {24'h0, CMD_EN_TX});
    repeat (gap) @(posedge clock);
    bus_req(REG_CMD, 1'b1, {24'h0, CMD_EN_TX});
    repeat (24) @(posedge clock);
    chk_count("en_tx accepted", exp_n, n_tx - n0);
  endtask : cmd_pair
  task automatic init_wait(output logic stalled);
    int n;
    n = 0;
    stalled = 1'b0;
    while (wr_log.size() < 2 && n < INIT_LIMIT_CYC) begin
      @(posedge clock);
      #1 if (ucode_stall === 1'b1 && wr_log.size() == 0) stalled = 1'b1;
      n++;
    end
  endtask : init_wait
  task automatic high_time(output int h);
    h = 0;
    repeat (60) begin
      #1 if (interrupt_out_n === 1'b1) h++;
      @(posedge clock);
    end
  endtask : high_time
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rd;
    logic [7:0]  id;
    logic [2:0]  ps;
    logic        st;
    int          n0;
    int          h;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1 chk_word("select after reset", {29'h0, PRESC_RST}, {29'h0, rate_prescale_select});
    cmd_pair(10, 1);
    bus_req(REG_CTRL, 1'b1, ctrl_word(1'b1, 1'b1, 3'h0, 8'hff));
    cmd_pair(10, 2);
    cmd_pair(0, 1);
    ta_req <= 1'b1;
    @(posedge clock);
    ta_req <= 1'b0;
    // init with the line busy and idle waiting off, then on
    line_active <= 1'b1;
    ucode_sync <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      seed = xs(seed);
      id = seed[7:0] | 8'h01;
      bus_req(REG_CTRL, 1'b1, ctrl_word(k == 0, 1'b1, 3'h0, 8'hff));
      wr_log.delete();
      bus_req(REG_NODE, 1'b1, {24'h0, id});
      if (k == 1) begin
        repeat (40) @(posedge clock);
        chk_count("writes while busy", 0, wr_log.size());
        line_active <= 1'b0;
      end
      init_wait(st);
      if (k == 0) chk_word("stall in init", 32'h0, {31'h0, st});
      chk_count("init writes", 2, wr_log.size());
      if (wr_log.size() >= 2) begin
        chk_word("init first", {INIT_ADDR0, INIT_SIG}, wr_log[0]);
        chk_word("init second", {INIT_ADDR1, id}, wr_log[1]);
      end
      line_active <= 1'b1;
      repeat (6) @(posedge clock);
      #1 chk_word("stall after init", 32'h1, {31'h0, ucode_stall});
    end
    line_active <= 1'b0;
    ucode_sync <= 1'b0;
    // prescale select through both paths
    for (int k = 0; k < 6; k++) begin
      seed = xs(seed);
      ps = seed[2:0];
      bus_req(REG_CTRL, 1'b1, ctrl_word(1'b1, k[0], ps, 8'hff));
      repeat (40) @(posedge clock);
      #1 chk_word("prescale", {29'h0, ps}, {29'h0, rate_prescale_select});
    end
    // lingering probe effects cleared only when refined
    for (int k = 0; k < 4; k++) begin
      bus_req(REG_CTRL, 1'b1, ctrl_word(1'b1, k[0], 3'h0, 8'hff));
      n0 = n_probe;
      bus_req(k[1] ? REG_NODE : REG_PROBE, 1'b1, 32'h0000005a);
      repeat (30) @(posedge clock);
      chk_count("probe clear", k[0] ? 1 : 0, n_probe - n0);
    end
    // soft reset, mask and enable prohibition, legacy then refined
    for (int r = 0; r < 2; r++) begin
      bus_req(REG_CTRL, 1'b1, ctrl_word(1'b1, r[0], 3'h0, 8'hff));
      // legacy through node zero, refined through the reset bit
      if (r == 0) bus_req(REG_NODE, 1'b1, {24'h0, NODE_ZERO});
      else bus_req(REG_CTRL, 1'b1, 32'h0000ff07);
      repeat (20) @(posedge clock);
      bus_rd(REG_STAT, rd);
      chk_word("status after soft reset", 32'h3, {30'h0, rd[ST_RI], rd[ST_TA]});
      bus_req(REG_CMD, 1'b1, {24'h0, CMD_EN_RX});
      repeat (24) @(posedge clock);
      ri_req <= 1'b1;
      @(posedge clock);
      ri_req <= 1'b0;
      repeat (8) @(posedge clock);
      #1 chk_word("irq after soft reset", {31'h0, r[0]}, {31'h0, interrupt_out_n});
      n0 = n_rx;
      bus_req(REG_CMD, 1'b1, {24'h0, CMD_EN_RX});
      repeat (40) @(posedge clock);
      chk_count("en_rx near return", r, n_rx - n0);
    end
    // interrupt raise and disable time, refined
    bus_req(REG_CTRL, 1'b1, ctrl_word(1'b1, 1'b1, 3'h0, 8'hff));
    bus_req(REG_CMD, 1'b1, {24'h0, CMD_EN_RX});
    repeat (24) @(posedge clock);
    ri_req <= 1'b1;
    @(posedge clock);
    ri_req <= 1'b0;
    repeat (10) @(posedge clock);
    #1 chk_word("irq on inhibit return", 32'h0, {31'h0, interrupt_out_n});
    bus_req(REG_CMD, 1'b1, {24'h0, CMD_CLR_IRQ});
    high_time(h);
    chk_count("off after clear", 1, long_enough(h));
    event_irq <= 1'b1;
    @(posedge clock);
    event_irq <= 1'b0;
    repeat (4) @(posedge clock);
    successor_own_a_rd <= 1'b1;
    @(posedge clock);
    successor_own_a_rd <= 1'b0;
    high_time(h);
    chk_count("off after read", 1, long_enough(h));
    end_of_test();
  end
endmodule : token_ctrl_init_and_timing_fixes_tb_top
`default_nettype wire
